/* hw/osb_pkg.sv */
// ----------------------------------------
// shared constants for output enable control
// ----------------------------------------
package osb_pkg;
  // number of gated clock outputs
  localparam int OSB_NOUT = 20;
  // first and last output owning an enable pin
  localparam int OSB_PIN_LO = 5;
  localparam int OSB_PIN_HI = 12;
  // positions inside the synchronised pin vector
  localparam int OSB_SI_DATA = 0;
  localparam int OSB_SI_SCLK = 1;
  localparam int OSB_SI_LOAD = 5;
  localparam int OSB_SI_SEL = 8;
  localparam int OSB_SI_PG = 9;
  localparam int OSB_SI_W = 10;
  // values after reset
  localparam logic [19:0] OSB_ENABLE_RST = 20'hfffff;
  localparam logic [19:0] OSB_MASK_RST = 20'h00000;
  // clock rate of mclk
  localparam int OSB_CLK_MHZ = 10;
  // enable_latency bound, in input clock cycles
  localparam int OSB_OELAT_MAX_CYC = 10;
  // load-to-effect window, in input clock cycles
  localparam int OSB_PROP_MIN_CYC = 4;
  localparam int OSB_PROP_MAX_CYC = 10;
  // powerdown_exit_latency, longest time
  localparam int OSB_PDLAT_US = 300;
  localparam int OSB_PDLAT_CYC = OSB_PDLAT_US * OSB_CLK_MHZ;
  // startup_settle_time, longest time, in us
  localparam int OSB_STAB_US = 1800;
  localparam int OSB_STAB_CYC = OSB_STAB_US * OSB_CLK_MHZ;
endpackage : osb_pkg

/* hw/osb_link_if.sv */
`timescale 1ns/1ps
// ----------------------------------------
// carrier between the control core and its helpers
// ----------------------------------------
interface osb_link_if;
  logic shift_tick; // one-cycle shift request
  logic shift_bit; // serial bit to shift in
  logic copy_now; // one-cycle copy to output register
  logic [19:0] held_bits; // side-band output register
  logic [19:0] enable_req; // wanted run state per output
  logic [19:0] out_run; // glitch-free run state
  modport ctl (output shift_tick, shift_bit, copy_now, enable_req,
               input held_bits, out_run);
  modport shifter (input shift_tick, shift_bit, copy_now, output held_bits);
  modport gate (input enable_req, output out_run);
endinterface : osb_link_if

/* hw/osb_shift_reg.sv */
`timescale 1ns/1ps
// ----------------------------------------
// side-band shift and output registers
// ----------------------------------------
module osb_shift_reg
  import osb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // link to the control core
  osb_link_if.shifter link
);
  logic [19:0] sr; // shift register
  logic [19:0] held; // output register
  logic [19:0] next_sr;
  logic [19:0] next_held;

  // next values: new bit enters at the top and walks down
  always_comb begin
    next_sr = sr;
    next_held = held;
    if (link.shift_tick) begin
      // first bit ends at output 0
      next_sr = {link.shift_bit, sr[19:1]};
    end
    if (link.copy_now) begin
      next_held = sr;
    end
  end

  // registers; both power up to all enabled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sr <= OSB_ENABLE_RST;
      held <= OSB_ENABLE_RST;
    end else begin
      sr <= next_sr;
      held <= next_held;
    end
  end

  assign link.held_bits = held;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_shift_entry: assert property (link.shift_tick |=>
    sr == {$past(link.shift_bit), $past(sr[19:1])}) else $error("shift entry wrong");
  a_copy_whole: assert property (link.copy_now |=> held == $past(sr))
    else $error("output register not copied");
  a_held_quiet: assert property (!link.copy_now |=> $stable(held))
    else $error("output register moved without copy");
endmodule : osb_shift_reg

/* hw/osb_enable_gate.sv */
`timescale 1ns/1ps
// ----------------------------------------
// shared enable synchroniser, clocked by input clock
// ----------------------------------------
module osb_enable_gate
  import osb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // link to the control core
  osb_link_if.gate link
);
  logic [19:0] stage; // first retiming stage
  logic [19:0] run; // final run state
  logic [19:0] next_stage;
  logic [19:0] next_run;

  // two stages: a change lands only on a clock boundary,
  // so an output never sees a cut pulse
  always_comb begin
    next_stage = link.enable_req;
    next_run = stage;
  end

  // outputs start stopped; power good is low after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      run <= '0;
    end else begin
      stage <= next_stage;
      run <= next_run;
    end
  end

  assign link.out_run = run;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_gate_two_stage: assert property (##2 run == $past(link.enable_req, 2))
    else $error("run not two cycles behind request");
endmodule : osb_enable_gate

/* hw/osb_output_enable.sv */
`timescale 1ns/1ps
// ----------------------------------------
// output enable and side-band control core
// ----------------------------------------
module osb_output_enable
  import osb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // strap and power pins
  input wire logic sideband_select_pin,
  input wire logic power_good_down_n,
  // enable pins, three shared with the serial link
  input wire logic enable5_or_serial_data,
  input wire logic enable6_or_serial_clock,
  input wire logic enable7_n,
  input wire logic enable8_n,
  input wire logic enable9_n,
  input wire logic enable10_or_load_line,
  input wire logic enable11_n,
  input wire logic enable12_n,
  // management writes, same clock domain
  input wire logic smbus_enable_wr,
  input wire logic [19:0] smbus_enable_wdata,
  input wire logic mask_wr,
  input wire logic [19:0] mask_wdata,
  // clock gating results
  output logic [19:0] out_run,
  // status
  output logic sideband_readback,
  output logic mask_access_ok,
  output logic device_started,
  output logic [19:0] smbus_enable,
  output logic [19:0] keep_enabled_mask
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  osb_link_if link ();

  osb_shift_reg u_shift (
    .mclk(mclk),
    .arst_n(arst_n),
    .link(link)
  );

  osb_enable_gate u_gate (
    .mclk(mclk),
    .arst_n(arst_n),
    .link(link)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] pin_raw; // all asynchronous pins
  logic [9:0] sync1; // first stage, read by sync2 only
  logic [9:0] sync2; // settled pin levels
  logic [1:0] prev; // previous load and serial clock
  logic [9:0] next_sync1;
  logic [9:0] next_sync2;
  logic [1:0] next_prev;

  // gather pins in index order of the package
  assign pin_raw = {power_good_down_n, sideband_select_pin, enable12_n,
                    enable11_n, enable10_or_load_line, enable9_n,
                    enable8_n, enable7_n, enable6_or_serial_clock,
                    enable5_or_serial_data};

  // next values of the sync chain
  always_comb begin
    next_sync1 = pin_raw;
    next_sync2 = sync1;
    // edge history is taken from the settled stage only
    next_prev = {sync2[OSB_SI_LOAD], sync2[OSB_SI_SCLK]};
  end

  // sync registers; pins read as low after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  // ----------------------------------------
  // decoded levels and edges
  // ----------------------------------------
  logic pg_ok; // power good, settled
  logic mode_sb; // side-band interface selected
  logic [7:0] pins_n; // enable pins 5..12, settled
  logic load_high; // load line high
  logic load_fall; // load line falling edge
  logic sclk_rise; // serial clock rising edge

  assign mode_sb = sync2[OSB_SI_SEL];
  assign pg_ok = sync2[OSB_SI_PG];
  assign pins_n = sync2[7:0];
  assign load_high = sync2[OSB_SI_LOAD];
  // limitation: flipping the select while pin 10 is high
  // looks like a load fall and copies the shift register
  assign load_fall = prev[1] & ~sync2[OSB_SI_LOAD];
  // the serial clock is sampled at 10 MHz, so a link
  // faster than a few MHz would lose edges here
  assign sclk_rise = sync2[OSB_SI_SCLK] & ~prev[0];

  // ----------------------------------------
  // serial link decode
  // ----------------------------------------
  // pins 5, 6, 10 become data, clock, load
  // load low hides clock and data
  // no power good term on purpose
  assign link.shift_tick = mode_sb & load_high & sclk_rise;
  assign link.shift_bit = sync2[OSB_SI_DATA];
  // copy here, gate adds two more
  assign link.copy_now = mode_sb & load_fall;

  // ----------------------------------------
  // management registers
  // ----------------------------------------
  logic [19:0] smb_en; // per-output enable bits
  logic [19:0] mask; // keep-enabled mask
  logic started; // first power good seen
  logic [19:0] next_smb_en;
  logic [19:0] next_mask;
  logic next_started;

  // next values of the management state
  always_comb begin
    next_smb_en = smb_en;
    next_mask = mask;
    // start latched by first power good
    next_started = started | pg_ok;
    if (smbus_enable_wr) begin
      next_smb_en = smbus_enable_wdata;
    end
    if (mask_wr && pg_ok) begin
      next_mask = mask_wdata;
    end
  end

  // management registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      smb_en <= OSB_ENABLE_RST;
      mask <= OSB_MASK_RST;
      started <= 1'b0;
    end else begin
      smb_en <= next_smb_en;
      mask <= next_mask;
      started <= next_started;
    end
  end

  // ----------------------------------------
  // enable request
  // ----------------------------------------
  logic [19:0] trad_req; // traditional mode decision
  logic [19:0] sb_req; // side-band mode decision
  logic [19:0] req; // final request to the gate

  // decide each output; the gate retimes the result
  always_comb begin
    trad_req = smb_en;
    // pins cover outputs 5 to 12
    for (int k = OSB_PIN_LO; k <= OSB_PIN_HI; k++) begin
      trad_req[k] = smb_en[k] & ~pins_n[k - OSB_PIN_LO];
    end
    sb_req = link.held_bits | mask;
    req = '0;
    if (pg_ok) begin
      req = mode_sb ? sb_req : trad_req;
    end
  end

  // pin path: two sync plus two gate cycles
  // power exit reaches outputs in four cycles
  // first clock follows the same four cycles
  assign link.enable_req = req;

  // ----------------------------------------
  // outputs, all taken from registers
  // ----------------------------------------
  // a stopped input clock freezes these, so outputs stop too
  assign out_run = link.out_run;
  assign sideband_readback = sync2[OSB_SI_SEL];
  assign mask_access_ok = sync2[OSB_SI_PG];
  assign device_started = started;
  assign smbus_enable = smb_en;
  assign keep_enabled_mask = mask;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_readback_live: assert property (##2
    sideband_readback == $past(sideband_select_pin, 2))
    else $error("readback not following select pin");

  a_load_gates_shift: assert property (!load_high |-> !link.shift_tick)
    else $error("shift while load line low");

  a_trad_no_shift: assert property (!mode_sb |->
    !link.shift_tick && !link.copy_now)
    else $error("serial link active in traditional mode");

  a_powerdown_low: assert property (!pg_ok |-> ##2 out_run == '0)
    else $error("output runs during power-down");

  a_mask_blocked: assert property (mask_wr && !pg_ok |=> $stable(mask))
    else $error("mask written during power-down");

  a_trad_pin_off: assert property (pg_ok && !mode_sb && pins_n[2]
    |-> ##2 !out_run[7])
    else $error("output 7 runs with its pin high");

  a_trad_pin_on: assert property (pg_ok && !mode_sb && !pins_n[3]
    && smb_en[8] |-> ##2 out_run[8])
    else $error("output 8 not started by its pin");

  a_mask_force: assert property (pg_ok && mode_sb && mask[3]
    |-> ##2 out_run[3])
    else $error("masked output not forced on");

  a_sb_ignore_pin: assert property (pg_ok && mode_sb && pins_n[4]
    && link.held_bits[9] |-> ##2 out_run[9])
    else $error("pin disabled output in side-band mode");

  a_load_to_run: assert property (link.copy_now ##1 (pg_ok && mode_sb)
    |-> ##2 out_run == ($past(link.held_bits, 2) | $past(mask, 2)))
    else $error("new setting not applied on time");

  a_sb_zero_low: assert property (pg_ok && mode_sb &&
    (link.held_bits | mask) == '0 |-> ##2 out_run == '0)
    else $error("output runs with mask and bit zero");

  a_enable_write: assert property (smbus_enable_wr |=>
    smbus_enable == $past(smbus_enable_wdata))
    else $error("enable bits not written");

  a_mask_write: assert property (mask_wr && pg_ok |=>
    keep_enabled_mask == $past(mask_wdata))
    else $error("mask not written with power good");

  a_trad_bit_off: assert property (pg_ok && !mode_sb && !smb_en[0]
    |-> ##2 !out_run[0])
    else $error("output 0 runs with its enable bit clear");

  a_load_while_down: assert property (mode_sb && load_fall && !pg_ok
    |-> link.copy_now)
    else $error("load refused during power-down");

  a_started_set: assert property (pg_ok |=> device_started)
    else $error("start not latched by power good");

  a_sb_pin_free: assert property (pg_ok && mode_sb && pins_n[7]
    && link.held_bits[12] |-> ##2 out_run[12])
    else $error("pin 12 disabled output in side-band mode");

  c_load_done: cover property (link.copy_now ##3 pg_ok);
  c_shift_seen: cover property (link.shift_tick && !pg_ok);
  c_run_start: cover property ($rose(out_run[0]));
  c_power_down: cover property ($fell(pg_ok) && started);
endmodule : osb_output_enable

/* bench/osb_sb_master.sv */
`timescale 1ns/1ps
// ----------------------------------------
// board controller on the side-band link
// ----------------------------------------
module osb_sb_master (
  // sampling clock of the board logic
  input wire logic mclk,
  // side-band lines
  output logic sb_data,
  output logic sb_clk,
  output logic sb_load
);
  // half of the 800 ns link period, in mclk cycles
  localparam int HALF = 4;

  // idle: clock parked low, device deselected
  initial begin
    sb_data = 1'b0;
    sb_clk = 1'b0;
    sb_load = 1'b0;
  end

  // wait some mclk edges
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask : ticks

  task automatic send(input logic [19:0] word);
    sb_load <= 1'b1;
    ticks(HALF);
    for (int i = 0; i < 20; i++) begin
      // output 0 bit goes out first
      sb_data <= word[i];
      ticks(HALF);
      // link clock well under 10 MHz
      sb_clk <= 1'b1;
      ticks(2);
      // hold over: line no longer shows the bit
      sb_data <= ~word[i];
      ticks(HALF - 2);
      sb_clk <= 1'b0;
    end
    ticks(HALF);
    // clock parked low, then load falls
    sb_load <= 1'b0;
    ticks(HALF);
  endtask : send

  // stray clocks with load low, to be ignored
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      sb_data <= ~sb_data;
      ticks(HALF);
      sb_clk <= 1'b1;
      ticks(HALF);
      sb_clk <= 1'b0;
    end
    ticks(HALF);
  endtask : stray
endmodule : osb_sb_master

/* bench/osb_output_enable_test.sv */
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench for output enable control
// ----------------------------------------
module osb_output_enable_test
  import osb_pkg::*;
;
  // clock and reset
  logic mclk;
  logic arst_n;
  // strap, power and enable pins
  logic sel;
  logic pg;
  logic [12:5] pin_n;
  // management writes
  logic en_wr;
  logic [19:0] en_wdata;
  logic m_wr;
  logic [19:0] m_wdata;
  // observed outputs
  logic [19:0] out_run;
  logic sb_rb;
  logic acc_ok;
  logic started;
  logic [19:0] en_rb;
  logic [19:0] mask_rb;
  // lines from the board controller
  logic sd;
  logic sc;
  logic sl;
  // tallies
  int n_fail;
  int checks;

  osb_sb_master i_osb_sb_master (.mclk(mclk), .sb_data(sd), .sb_clk(sc), .sb_load(sl));

  // shared pins follow the controller only in side-band mode
  osb_output_enable i_osb_output_enable (
    .mclk(mclk), .arst_n(arst_n), .sideband_select_pin(sel), .power_good_down_n(pg),
    .enable5_or_serial_data(sel ? sd : pin_n[5]),
    .enable6_or_serial_clock(sel ? sc : pin_n[6]),
    .enable7_n(pin_n[7]), .enable8_n(pin_n[8]), .enable9_n(pin_n[9]),
    .enable10_or_load_line(sel ? sl : pin_n[10]),
    .enable11_n(pin_n[11]), .enable12_n(pin_n[12]),
    .smbus_enable_wr(en_wr), .smbus_enable_wdata(en_wdata),
    .mask_wr(m_wr), .mask_wdata(m_wdata), .out_run(out_run),
    .sideband_readback(sb_rb), .mask_access_ok(acc_ok), .device_started(started),
    .smbus_enable(en_rb), .keep_enabled_mask(mask_rb));

  // 10 MHz input clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask : ticks

  // bounded wait on the run vector; a miss ends the run
  task automatic wait_run(input logic [19:0] exp, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk);
      if (out_run === exp) break;
    end
    chk(out_run, exp);
    if (out_run !== exp) end_sim();
  endtask : wait_run

  // one-cycle write pulse to enable bits or mask
  task automatic reg_wr(input logic is_mask, input logic [19:0] v);
    en_wr <= ~is_mask;
    m_wr <= is_mask;
    en_wdata <= v;
    m_wdata <= v;
    ticks(1);
    en_wr <= 1'b0;
    m_wr <= 1'b0;
    ticks(1);
  endtask : reg_wr

  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // values after reset
  task automatic t_reset();
    chk(en_rb, OSB_ENABLE_RST);
    chk(mask_rb, OSB_MASK_RST);
    chk(out_run, 20'h00000);
    chk({19'h0, started}, 20'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_trad();
    pg <= 1'b1;
    wait_run(20'hfffff, OSB_PDLAT_CYC);
    chk({19'h0, started}, 20'h1);
    chk({19'h0, acc_ok}, 20'h1);
    chk({19'h0, sb_rb}, 20'h0);
    for (int k = OSB_PIN_LO; k <= OSB_PIN_HI; k++) begin
      pin_n[k] <= 1'b1;
      wait_run(~(20'h1 << k), OSB_OELAT_MAX_CYC);
      pin_n[k] <= 1'b0;
      wait_run(20'hfffff, OSB_OELAT_MAX_CYC);
    end
    reg_wr(1'b0, 20'hfff7e);
    chk(en_rb, 20'hfff7e);
    wait_run(20'hfff7e, OSB_OELAT_MAX_CYC);
    // mask has no say in this mode
    reg_wr(1'b1, 20'h00081);
    chk(mask_rb, 20'h00081);
    ticks(OSB_PROP_MAX_CYC);
    chk(out_run, 20'hfff7e);
    reg_wr(1'b0, OSB_ENABLE_RST);
    reg_wr(1'b1, OSB_MASK_RST);
    $display("test traditional done");
  endtask : t_trad

  task automatic t_sb();
    pin_n <= 8'hff;
    sel <= 1'b1;
    ticks(12);
    chk({19'h0, sb_rb}, 20'h1);
    chk(out_run, 20'hfffff);
    reg_wr(1'b0, 20'h00000);
    i_osb_sb_master.send(20'h5a3c1);
    chk(out_run, 20'hfffff);
    wait_run(20'h5a3c1, 7);
    reg_wr(1'b1, 20'h0000f);
    wait_run(20'h5a3cf, OSB_PROP_MAX_CYC);
    // clock and data wiggle with load low: nothing may move
    i_osb_sb_master.stray(3);
    ticks(OSB_PROP_MAX_CYC);
    chk(out_run, 20'h5a3cf);
    $display("test side-band done");
  endtask : t_sb

  task automatic t_pwr();
    pg <= 1'b0;
    wait_run(20'h00000, OSB_PROP_MAX_CYC);
    chk({19'h0, acc_ok}, 20'h0);
    reg_wr(1'b1, 20'hf0000);
    chk(mask_rb, 20'h0000f);
    i_osb_sb_master.send(20'h00f30);
    ticks(OSB_PROP_MAX_CYC);
    chk(out_run, 20'h00000);
    pg <= 1'b1;
    wait_run(20'h00f3f, OSB_PROP_MAX_CYC);
    $display("test power-down done");
  endtask : t_pwr

  task automatic t_back();
    sel <= 1'b0;
    pin_n <= 8'h00;
    wait_run(20'h00000, 12);
    chk({19'h0, sb_rb}, 20'h0);
    reg_wr(1'b0, 20'h80001);
    wait_run(20'h80001, OSB_OELAT_MAX_CYC);
    $display("test mode return done");
  endtask : t_back

  // main sequence
  initial begin
    n_fail = 0;
    checks = 0;
    arst_n = 1'b0;
    sel = 1'b0;
    pg = 1'b0;
    pin_n = 8'h00;
    en_wr = 1'b0;
    m_wr = 1'b0;
    en_wdata = 20'h00000;
    m_wdata = 20'h00000;
    ticks(2);
    arst_n <= 1'b1;
    ticks(1);
    t_reset();
    t_trad();
    t_sb();
    t_pwr();
    t_back();
    end_sim();
  end
endmodule : osb_output_enable_test
